// ===== logic/hdr_cmp_pkg.sv
// Constants, register map and encodings of the IP/UDP/ACH header comparator stage.
// Assumes a 32-bit AXI4-Lite register bus and a byte-wide header stream.
package hdr_cmp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PAIR_A = 8'h04;
   localparam logic [7:0] OFF_MATCH_B_LO = 8'h08;
   localparam logic [7:0] OFF_MATCH_B_HI = 8'h0C;
   localparam logic [7:0] OFF_MASK_B_LO = 8'h10;
   localparam logic [7:0] OFF_MASK_B_HI = 8'h14;
   localparam logic [7:0] OFF_OFFSETS = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam int NUM_REGS = 8;
   localparam int IDX_CTRL = OFF_CTRL / 4;
   localparam int IDX_PAIR_A = OFF_PAIR_A / 4;
   localparam int IDX_MATCH_B_LO = OFF_MATCH_B_LO / 4;
   localparam int IDX_MATCH_B_HI = OFF_MATCH_B_HI / 4;
   localparam int IDX_MASK_B_LO = OFF_MASK_B_LO / 4;
   localparam int IDX_MASK_B_HI = OFF_MASK_B_HI / 4;
   localparam int IDX_OFFSETS = OFF_OFFSETS / 4;
   localparam int IDX_STATUS = OFF_STATUS / 4;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_STAGE_LSB = 4;
   localparam int CTRL_ZERO_BIT = 8;
   localparam int CTRL_FIXUP_BIT = 9;
   localparam int CTRL_SIZE_LSB = 12;
   localparam int PA_MATCH_LSB = 0;
   localparam int PA_MASK_LSB = 8;
   localparam int PA_OFF_LSB = 16;
   localparam int OFS_B_LSB = 0;
   localparam int OFS_LEN_LSB = 8;
   localparam int OFS_FLOW_LSB = 16;
   localparam int OFS_CSUM_LSB = 24;
   localparam int ST_COUNT_LSB = 16;

   // Reset values and writable bits
   localparam logic [31:0] CTRL_RST = 32'h0000_2000;
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_3373;
   localparam logic [31:0] PAIR_A_WMASK = 32'h001F_FFFF;
   localparam logic [31:0] FULL_WMASK = 32'hFFFF_FFFF;
   localparam logic [31:0] OFFSETS_WMASK = 32'hFF1F_FF7F;

   typedef enum logic [1:0] {
      MODE_IPV4 = 2'h0,
      MODE_IPV6 = 2'h1,
      MODE_OTHER32 = 2'h2,
      MODE_OTHER128 = 2'h3
   } hdr_mode_t;

   localparam logic [2:0] STAGE_ETH2 = 3'h1;
   localparam logic [2:0] STAGE_IP1 = 3'h2;
   localparam logic [2:0] STAGE_IP2 = 3'h3;
   localparam logic [2:0] STAGE_PTP_OAM = 3'h5;
   localparam logic [3:0] VERSION_IPV4 = 4'h4;
   localparam logic [3:0] VERSION_IPV6 = 4'h6;
   localparam logic [7:0] FRAG_HI_POS = 8'h06;
   localparam logic [7:0] FRAG_LO_POS = 8'h07;
   localparam int MORE_FRAGMENTS_BIT = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb,
                                              input logic [31:0] wmask);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return (res & wmask) | (old_v & ~wmask);
   endfunction

endpackage

// ===== logic/masked_window_match.sv
// Masked match of a window of NBYTES header bytes starting at a programmed position.
// Assumes bytes arrive in order with a position count from the header start.
`timescale 1ns/1ps
`default_nettype none
module masked_window_match #(
   parameter int NBYTES = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic byte_valid,
   input wire logic byte_first,
   input wire logic [7:0] byte_pos,
   input wire logic [7:0] byte_data,
   input wire logic [7:0] start_pos,
   input wire logic [8*NBYTES-1:0] match,
   input wire logic [8*NBYTES-1:0] mask,
   output logic window_ok
);
   generate
      if (NBYTES < 1 || NBYTES > 8) begin : g_chk
         $error("masked_window_match: NBYTES must be 1 to 8");
      end
   endgenerate

   logic miss_r;
   logic [3:0] seen_r;
   logic [8:0] rel;
   logic in_win;
   logic [7:0] m_byte;
   logic [7:0] k_byte;
   logic bad;

   always_comb begin
      rel = {1'b0, byte_pos} - {1'b0, start_pos};
      in_win = byte_valid && !rel[8] && (rel < 9'(NBYTES));
      // First byte of the window sits in the most significant byte
      m_byte = match[8*NBYTES-1 - 8*rel[2:0] -: 8];
      k_byte = mask[8*NBYTES-1 - 8*rel[2:0] -: 8];
      bad = in_win && (((byte_data ^ m_byte) & k_byte) != 8'h00);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         miss_r <= 1'b0;
         seen_r <= 4'h0;
      end else if (byte_valid) begin
         miss_r <= (byte_first ? 1'b0 : miss_r) | bad;
         seen_r <= (byte_first ? 4'h0 : seen_r) + {3'h0, in_win};
      end
   end

   // A zero mask disables the pair; a header too short to hold the window fails
   assign window_ok = (mask == '0) || (!miss_r && seen_r == 4'(NBYTES));

   AST_MISS_STICKS: assert property (@(posedge aclk) disable iff (!aresetn)
      bad |=> miss_r)
      else $error("masked mismatch not recorded");
endmodule
`default_nettype wire

// ===== logic/ip_ach_header_comparator.sv
// IP/UDP/ACH header comparator stage with its AXI4-Lite register file.
// Assumes a byte stream of the header from its first byte; results go to the next stage.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ip_ach_header_comparator #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hdr_valid,
   input wire logic hdr_first,
   input wire logic hdr_last,
   input wire logic [7:0] hdr_data,
   output logic hdr_done,
   output logic hdr_verified,
   output logic [2:0] next_stage,
   output logic [7:0] next_hdr_offset,
   output logic [4:0] flow_offset,
   output logic flow_wide,
   output logic csum_zero,
   output logic csum_fixup,
   output logic csum_loc_valid,
   output logic [7:0] csum_loc,
   output logic [1:0] csum_size
);
   import hdr_cmp_pkg::*;

   if (ADDR_W < 6) begin : g_chk
      $error("ip_ach_header_comparator: ADDR_W must be at least 6");
   end

   // Register file
   logic [31:0] regs_r [NUM_REGS];
   logic aw_full_r, w_full_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [2:0] widx, ridx;
   logic waddr_hit, raddr_hit, do_write;

   // Header tracking and results
   logic [7:0] pos_r, cur_pos, byte0_r;
   logic frag_bad_r, eval_r;
   logic [15:0] check_cnt_r;
   logic [5:0] last_checks_r;

   // Field views
   hdr_mode_t mode;
   logic [2:0] stage_sel;
   logic zero_en, fixup_en;
   logic [1:0] size_sel;
   logic [7:0] match_a, mask_a;
   logic [4:0] off_a;
   logic [63:0] match_b, mask_b;
   logic [6:0] off_b;
   logic [7:0] hdr_len;
   logic [4:0] flow_off;
   logic [7:0] csum_off;
   logic a_ok, b_ok, ver_ok, frag_ok, len_ok, stage_rsvd, all_ok;

   assign mode = hdr_mode_t'(regs_r[IDX_CTRL][CTRL_MODE_LSB +: 2]);
   assign stage_sel = regs_r[IDX_CTRL][CTRL_STAGE_LSB +: 3];
   assign zero_en = regs_r[IDX_CTRL][CTRL_ZERO_BIT];
   assign fixup_en = regs_r[IDX_CTRL][CTRL_FIXUP_BIT];
   assign size_sel = regs_r[IDX_CTRL][CTRL_SIZE_LSB +: 2];
   assign match_a = regs_r[IDX_PAIR_A][PA_MATCH_LSB +: 8];
   assign mask_a = regs_r[IDX_PAIR_A][PA_MASK_LSB +: 8];
   assign off_a = regs_r[IDX_PAIR_A][PA_OFF_LSB +: 5];
   assign match_b = {regs_r[IDX_MATCH_B_HI], regs_r[IDX_MATCH_B_LO]};
   assign mask_b = {regs_r[IDX_MASK_B_HI], regs_r[IDX_MASK_B_LO]};
   assign off_b = regs_r[IDX_OFFSETS][OFS_B_LSB +: 7];
   assign hdr_len = regs_r[IDX_OFFSETS][OFS_LEN_LSB +: 8];
   assign flow_off = regs_r[IDX_OFFSETS][OFS_FLOW_LSB +: 5];
   assign csum_off = regs_r[IDX_OFFSETS][OFS_CSUM_LSB +: 8];

   // AXI4-Lite write path: address and data taken in either order
   assign widx = awaddr_r[4:2];
   assign waddr_hit = (awaddr_r[ADDR_W-1:5] == '0) && (widx != 3'(IDX_STATUS));
   assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         awaddr_r <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_full_r <= 1'b0;
      end else if (!aw_full_r && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_full_r <= 1'b0;
      end else if (!w_full_r && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= waddr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Status word is rebuilt from live state, so it is never stored in the array
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         regs_r[IDX_CTRL] <= CTRL_RST;
         for (int i = 1; i < NUM_REGS; i++) begin
            regs_r[i] <= ZERO_RST;
         end
      end else if (do_write && waddr_hit) begin
         case (widx)
            3'(IDX_CTRL):
               regs_r[widx] <= apply_strb(regs_r[widx], wdata_r, wstrb_r, CTRL_WMASK);
            3'(IDX_PAIR_A):
               regs_r[widx] <= apply_strb(regs_r[widx], wdata_r, wstrb_r, PAIR_A_WMASK);
            3'(IDX_OFFSETS):
               regs_r[widx] <= apply_strb(regs_r[widx], wdata_r, wstrb_r, OFFSETS_WMASK);
            default:
               regs_r[widx] <= apply_strb(regs_r[widx], wdata_r, wstrb_r, FULL_WMASK);
         endcase
      end
   end

   // AXI4-Lite read path: one read at a time
   assign ridx = s_axi_araddr[4:2];
   assign raddr_hit = (s_axi_araddr[ADDR_W-1:5] == '0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= raddr_hit ? RESP_OKAY : RESP_SLVERR;
         if (!raddr_hit) begin
            s_axi_rdata <= 32'h0000_0000;
         end else if (ridx == 3'(IDX_STATUS)) begin
            s_axi_rdata <= {check_cnt_r, 9'h000, last_checks_r, hdr_verified};
         end else begin
            s_axi_rdata <= regs_r[ridx];
         end
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (!s_axi_arready) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Header byte position; saturates so long payloads cannot wrap onto a window
   assign cur_pos = hdr_first ? 8'h00 : pos_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_r <= 8'h00;
      end else if (hdr_valid) begin
         pos_r <= (cur_pos == 8'hFF) ? 8'hFF : cur_pos + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         byte0_r <= 8'h00;
      end else if (hdr_valid && cur_pos == 8'h00) begin
         byte0_r <= hdr_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frag_bad_r <= 1'b0;
      end else if (hdr_valid) begin
         if (cur_pos == FRAG_HI_POS) begin
            frag_bad_r <= hdr_data[MORE_FRAGMENTS_BIT] || (hdr_data[4:0] != 5'h00);
         end else if (cur_pos == FRAG_LO_POS) begin
            frag_bad_r <= frag_bad_r || (hdr_data != 8'h00);
         end else if (hdr_first) begin
            frag_bad_r <= 1'b0;
         end
      end
   end

   // Pair A: one byte, protocol or next-header field
   masked_window_match #(
      .NBYTES(1)
   ) u_pair_a (
      .aclk(aclk), .aresetn(aresetn),
      .byte_valid(hdr_valid), .byte_first(hdr_first),
      .byte_pos(cur_pos), .byte_data(hdr_data),
      .start_pos({3'h0, off_a}),
      .match(match_a),
      .mask(mask_a), .window_ok(a_ok)
   );
   // Pair B: eight bytes for IPSec, ACH or UDP ports
   masked_window_match #(
      .NBYTES(8)
   ) u_pair_b (
      .aclk(aclk), .aresetn(aresetn),
      .byte_valid(hdr_valid), .byte_first(hdr_first),
      .byte_pos(cur_pos), .byte_data(hdr_data),
      .start_pos({1'b0, off_b}),
      .match(match_b),
      .mask(mask_b), .window_ok(b_ok)
   );

   always_comb begin
      case (mode)
         MODE_IPV4: ver_ok = (byte0_r[7:4] == VERSION_IPV4);
         MODE_IPV6: ver_ok = (byte0_r[7:4] == VERSION_IPV6);
         default: ver_ok = 1'b1;
      endcase
      // A header shorter than the fragment field fails in IPv4
      frag_ok = (mode != MODE_IPV4) || (!frag_bad_r && pos_r > FRAG_LO_POS);
      // In IPv4 the length field counts 32-bit words and must agree with the programmed length
      len_ok = (mode != MODE_IPV4) || ({2'b00, byte0_r[3:0], 2'b00} == hdr_len);
      stage_rsvd = !(stage_sel == STAGE_ETH2 || stage_sel == STAGE_IP1 ||
                     stage_sel == STAGE_IP2 || stage_sel == STAGE_PTP_OAM);
      all_ok = ver_ok && frag_ok && len_ok && a_ok && b_ok;
   end

   // Evaluation follows the last header byte by one cycle, once matchers settle
   always_ff @(posedge aclk) begin
      eval_r <= aresetn && hdr_valid && hdr_last;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hdr_done <= 1'b0;
         hdr_verified <= 1'b0;
         last_checks_r <= 6'h00;
         check_cnt_r <= 16'h0000;
      end else begin
         hdr_done <= eval_r;
         if (eval_r) begin
            hdr_verified <= all_ok;
            last_checks_r <= {stage_rsvd, len_ok, b_ok, a_ok, frag_ok, ver_ok};
            check_cnt_r <= check_cnt_r + 16'h0001;
         end
      end
   end

   // Hand-off fields are sampled with the result so they stay coherent with it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         next_stage <= 3'h0;
         next_hdr_offset <= 8'h00;
         flow_offset <= 5'h00;
         flow_wide <= 1'b0;
      end else if (eval_r) begin
         next_stage <= stage_sel;
         next_hdr_offset <= hdr_len;
         flow_offset <= flow_off;
         flow_wide <= (mode == MODE_IPV6) || (mode == MODE_OTHER128);
      end
   end

   // If both enables are set anyway in IPv4, clearing wins and fixup is dropped; in other modes fixup is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csum_zero <= 1'b0;
         csum_fixup <= 1'b0;
         csum_loc_valid <= 1'b0;
         csum_loc <= 8'h00;
         csum_size <= 2'h0;
      end else if (eval_r) begin
         csum_zero <= zero_en && (mode == MODE_IPV4);
         csum_fixup <= fixup_en && !(zero_en && mode == MODE_IPV4);
         csum_loc_valid <= (mode == MODE_IPV4);
         csum_loc <= (mode == MODE_IPV4) ? csum_off : 8'h00;
         csum_size <= size_sel;
      end
   end

   AST_VERSION_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && !ver_ok |=> hdr_done && !hdr_verified)
      else $error("wrong version accepted");
   AST_FRAG_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && mode == MODE_IPV4 && frag_bad_r |=> !hdr_verified)
      else $error("fragment accepted in IPv4");
   AST_ALL_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && all_ok |=> hdr_done && hdr_verified)
      else $error("passing header not verified");
   AST_PAIR_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && (!a_ok || !b_ok) |=> !hdr_verified)
      else $error("pair mismatch accepted");
   AST_LEN_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r ##1 hdr_done |-> next_hdr_offset == $past(hdr_len))
      else $error("header length not handed on");
   AST_STAGE_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
      hdr_done |-> next_stage == $past(stage_sel) && flow_offset == $past(flow_off))
      else $error("next stage or flow offset wrong");
   AST_ZERO_V4: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && mode != MODE_IPV4 |=> !csum_zero && !csum_loc_valid)
      else $error("IPv4-only checksum output outside IPv4");
   AST_WIDE_FLOW: assert property (@(posedge aclk) disable iff (!aresetn)
      eval_r && mode == MODE_OTHER128 |=> flow_wide)
      else $error("128-bit flow width not reported");
   AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
endmodule
`default_nettype wire

// ===== test/hdr_feed.sv
// Upstream stage model: streams header bytes of frame, byte 0 first.
// Assumes go is pulsed only while idle; slow inserts idle gaps.
`timescale 1ns/1ps
`default_nettype none
module hdr_feed (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic slow,
   input wire logic [255:0] frame,
   input wire logic [5:0] len,
   output logic hdr_valid,
   output logic hdr_first,
   output logic hdr_last,
   output logic [7:0] hdr_data
);
   logic [5:0] idx_r = 6'h00;
   logic busy_r = 1'b0;
   logic gap_r = 1'b0;
   logic [7:0] junk_r = 8'hA5;
   always_ff @(posedge aclk) begin
      // Idle data keeps moving so a stale byte never looks valid
      junk_r <= {junk_r[6:0], ~junk_r[7]};
      gap_r <= slow & ~gap_r & aresetn;
      if (!aresetn) begin
         busy_r <= 1'b0;
      end else if (go && !busy_r) begin
         busy_r <= 1'b1;
         idx_r <= 6'h00;
      end else if (hdr_valid) begin
         idx_r <= idx_r + 6'h01;
         busy_r <= !hdr_last;
      end
   end
   assign hdr_valid = busy_r & ~gap_r;
   assign hdr_first = hdr_valid && idx_r == 6'h00;
   assign hdr_last = hdr_valid && idx_r == len - 6'h01;
   assign hdr_data = hdr_valid ? frame[8*idx_r +: 8] : junk_r;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the header comparator stage.
// Assumes hdr_feed upstream; expectations queued, checked by a watcher.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hdr_cmp_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, slow = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [255:0] f = '0;
   logic [5:0] len = 6'h18;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, csum_size, mode, csz;
   logic [31:0] s_axi_rdata;
   logic hdr_valid, hdr_first, hdr_last, hdr_done, hdr_verified, flow_wide;
   logic csum_zero, csum_fixup, csum_loc_valid, zen, fen;
   logic [7:0] hdr_data, next_hdr_offset, csum_loc, ma, ka, hl, cl;
   logic [2:0] next_stage, stage;
   logic [4:0] flow_offset, oa, fo;
   logic [6:0] ob;
   logic [63:0] mb, kb;
   logic [33:0] bq[$];
   logic [30:0] hq[$];
   int num_errors = 0, n_tests = 0;

   ip_ach_header_comparator #(.ADDR_W(8)) i_ip_ach_header_comparator (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hdr_valid, .hdr_first, .hdr_last,
      .hdr_data, .hdr_done, .hdr_verified, .next_stage, .next_hdr_offset, .flow_offset,
      .flow_wide, .csum_zero, .csum_fixup, .csum_loc_valid, .csum_loc, .csum_size);
   hdr_feed i_hdr_feed (.aclk, .aresetn, .go, .slow, .frame(f), .len, .hdr_valid,
      .hdr_first, .hdr_last, .hdr_data);

   always #12.5 aclk = ~aclk;

   task automatic finish_test();
      $display("Checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk_to(input int t);
      if (t >= 99) begin
         num_errors++;
         finish_test();
      end
   endtask

   task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t bus exp %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_hdr(input logic [30:0] e, input logic [30:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t hdr exp %h got %h", $time, e, g);
      end
   endtask

   // One write at a time; each valid dropped only at its own ready
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF, input logic [1:0] r = RESP_OKAY);
      int t;
      @(posedge aclk);
      bq.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         t++;
      end while (s_axi_bvalid !== 1'b1 && t < 99);
      s_axi_bready <= 1'b0;
      chk_to(t);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
      int t;
      @(posedge aclk);
      bq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         t++;
      end while (s_axi_rvalid !== 1'b1 && t < 99);
      s_axi_rready <= 1'b0;
      chk_to(t);
   endtask

   task automatic cfg();
      axw(OFF_CTRL, {18'h0, csz, 2'h0, fen, zen, 1'b0, stage, 2'h0, mode});
      axw(OFF_PAIR_A, {11'h0, oa, ka, ma});
      axw(OFF_MATCH_B_LO, mb[31:0]);
      axw(OFF_MATCH_B_HI, mb[63:32]);
      axw(OFF_MASK_B_LO, kb[31:0]);
      axw(OFF_MASK_B_HI, kb[63:32]);
      axw(OFF_OFFSETS, {cl, 3'h0, fo, hl, 1'b0, ob});
   endtask

   // Status bits then result outputs, from the current settings
   function automatic logic [37:0] model(input logic [255:0] b, input int n);
      logic v, fr, a, m, l, t, z, q;
      q = mode == 2'h0;
      v = mode[1] || b[7:4] == (mode[0] ? VERSION_IPV6 : VERSION_IPV4);
      fr = !q || (n >= 8 && b[53] == 1'b0 && b[52:48] == 5'h00 && b[63:56] == 8'h00);
      l = !q || {b[3:0], 2'b00} == hl;
      a = ka == 8'h00 || (oa < n && ((b[8*oa +: 8] ^ ma) & ka) == 8'h00);
      m = kb == 64'h0 || ob + 8 <= n;
      for (int k = 0; k < 8; k++) begin
         if (((b[8*(ob+k) +: 8] ^ mb[63-8*k -: 8]) & kb[63-8*k -: 8]) != 8'h00) m = 1'b0;
      end
      t = v & fr & a & m & l;
      z = zen && q;
      return {!(stage inside {STAGE_ETH2, STAGE_IP1, STAGE_IP2, STAGE_PTP_OAM}), l, m, a, fr, v,
              t, t, stage, hl, fo, mode[0], z, fen & ~z, q, q ? cl : 8'h00, csz};
   endfunction

   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         cmp_bus(bq.size() ? bq.pop_front() : '1, {s_axi_bresp, 32'h0});
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         cmp_bus(bq.size() ? bq.pop_front() : '1, {s_axi_rresp, s_axi_rdata});
      end
      if (hdr_done === 1'b1) begin
         cmp_hdr(hq.size() ? hq.pop_front() : '1, {hdr_verified, next_stage,
            next_hdr_offset, flow_offset, flow_wide, csum_zero, csum_fixup, csum_loc_valid,
            csum_loc, csum_size});
      end
   end

   initial begin
      logic [31:0] w;
      logic [255:0] fb;
      logic [6:0] sta;
      logic [30:0] res;
      int t, kind, n;
      void'($urandom(97));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) axr(8'(4 * i), i == 0 ? CTRL_RST : ZERO_RST);
      axr(8'h20, 32'h0, RESP_SLVERR);
      axw(OFF_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      axw(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      for (int i = 1; i < 7; i++) begin
         w = $urandom();
         axw(8'(4 * i), w);
         axr(8'(4 * i), w & (i == 1 ? PAIR_A_WMASK : i == 6 ? OFFSETS_WMASK : FULL_WMASK));
      end
      axw(OFF_OFFSETS, ~w, 4'h2);
      axr(OFF_OFFSETS, (w & 32'hFFFF_00FF | ~w & 32'h0000_FF00) & OFFSETS_WMASK);
      w = $urandom() & 32'hFFFF_FDFF;
      axw(OFF_CTRL, w);
      axr(OFF_CTRL, w & CTRL_WMASK);
      axr(OFF_STATUS, 32'h0);
      for (int it = 0; it < 40; it++) begin
         mode = 2'(it);
         kind = (it / 4) % 8;
         n = kind == 7 ? 6 : 24;
         for (int k = 0; k < 8; k++) fb[32*k +: 32] = $urandom();
         if (!mode[1]) fb[7:0] = {mode[0] ? VERSION_IPV6 : VERSION_IPV4, 4'h5};
         if (mode == 2'h0) fb[63:48] = 16'h0;
         if (kind == 1) fb[7:4] = fb[7:4] ^ 4'h1;
         if (kind == 2) fb[53] = 1'b1;
         if (kind == 3) fb[56] = 1'b1;
         hl = kind == 5 ? 8'h18 : 8'h14;
         oa = mode == 2'h0 ? 5'h09 : mode == 2'h1 ? 5'h06 : 5'($urandom_range(23));
         ka = kind == 5 ? 8'h00 : 8'($urandom()) | 8'h01;
         ma = fb[8*oa +: 8] ^ (8'($urandom()) & ~ka) ^ {7'h0, kind == 4};
         ob = kind == 6 ? 7'h14 : 7'($urandom_range(16));
         kb = kind == 5 ? 64'h0 : {$urandom(), $urandom()};
         for (int k = 0; k < 8; k++) mb[63-8*k -: 8] = fb[8*(ob+k) +: 8];
         mb = mb ^ ({$urandom(), $urandom()} & ~kb);
         stage = 3'($urandom());
         zen = 1'($urandom());
         fen = 1'($urandom()) & ~zen;
         csz = 2'($urandom());
         fo = 5'($urandom());
         cl = 8'($urandom());
         slow <= it % 3 == 0;
         len <= 6'(n);
         f <= fb;
         cfg();
         {sta, res} = model(fb, n);
         hq.push_back(res);
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
         t = 0;
         do begin
            @(posedge aclk);
            t++;
         end while (hq.size() != 0 && t < 99);
         chk_to(t);
         axr(OFF_STATUS, {16'(it + 1), 9'h0, sta});
      end
      // Reset in mid-header: no result may follow, registers start over
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(OFF_CTRL, CTRL_RST);
      axr(OFF_STATUS, 32'h0);
      repeat (60) @(posedge aclk);
      finish_test();
   end
endmodule
`default_nettype wire
